// ==== hw/quad_uart_pkg.sv ====
// shared constants, carriers and helpers for the quad uart pin logic
package quad_uart_pkg;
    localparam int NUM_CH = 4;
    localparam int LVL_W = 7;
    localparam logic [LVL_W-1:0] FIFO_DEPTH = 7'h40;
    // register offsets inside each channel
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_FCR = 3'h2;
    localparam logic [2:0] REG_MCR = 3'h4;
    localparam logic [2:0] REG_MSR = 3'h6;
    localparam logic [2:0] REG_EFR = 3'h7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // field positions
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_IR_BIT = 6;
    localparam int EFR_AUTO_RTS_BIT = 6;
    localparam int EFR_AUTO_CTS_BIT = 7;
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_DMA_BIT = 3;
    localparam int FCR_TRIG_LSB = 6;
    localparam int MSR_CTS_BIT = 4;
    // receive trigger levels selected by the fifo control field
    localparam logic [LVL_W-1:0] RX_TRIG_0 = 7'h08;
    localparam logic [LVL_W-1:0] RX_TRIG_1 = 7'h10;
    localparam logic [LVL_W-1:0] RX_TRIG_2 = 7'h38;
    localparam logic [LVL_W-1:0] RX_TRIG_3 = 7'h3C;
    // serial timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_NS = 128;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int IR_PULSE_CYCLES = (BIT_CYCLES * 3) / 16;
    localparam logic [4:0] BIT_LAST = 5'(BIT_CYCLES - 1);
    localparam logic [4:0] IR_PULSE = 5'(IR_PULSE_CYCLES);
    localparam logic [3:0] FRAME_LAST = 4'h9;

    typedef struct packed {
        logic [7:0] interrupt_enable_reg;
        logic [7:0] fcr;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_feature_reg;
    } chan_cfg_t;

    typedef struct packed {
        logic [LVL_W-1:0] tx_level;
        logic [LVL_W-1:0] rx_level;
    } fifo_fill_t;

    typedef struct packed {
        logic [3:0] cs_n;
        logic [2:0] addr;
        logic rd_n;
        logic wr_n;
        logic sel_n;
        logic [7:0] data;
        logic [3:0] cts_n;
        logic [3:0] rx;
    } pins_t;

    // receive trigger level chosen by the fifo control register
    function automatic logic [LVL_W-1:0] rx_trigger(input logic [7:0] fcr);
        case (fcr[FCR_TRIG_LSB+:2])
            2'h0: rx_trigger = RX_TRIG_0;
            2'h1: rx_trigger = RX_TRIG_1;
            2'h2: rx_trigger = RX_TRIG_2;
            default: rx_trigger = RX_TRIG_3;
        endcase
    endfunction

    // ready signalling uses the level mode only with fifo and dma mode on
    function automatic logic dma_mode1(input logic [7:0] fcr);
        dma_mode1 = fcr[FCR_EN_BIT] & fcr[FCR_DMA_BIT];
    endfunction
endpackage

// ==== hw/uart_lane.sv ====
// one channel transmit serialiser with infrared encoder and receive decoder
`timescale 1ns/1ns
module uart_lane
    import quad_uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ir_mode_i,
    input wire logic cts_ok_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    output logic tx_std_o,
    output logic tx_ir_o,
    input wire logic rx_pin_i,
    output logic rx_bit_o
);
    typedef struct packed {
        logic busy;
        logic ready;
        logic [9:0] shift;
        logic [3:0] bitn;
        logic [4:0] tick;
        logic std;
        logic ir;
        logic [4:0] rcnt;
        logic rx_bit;
    } lane_state_t;

    lane_state_t s_reg;
    lane_state_t s_next;

    // frame sender, ir pulse encoder and ir pulse stretcher
    always_comb
    begin
        s_next = s_reg;
        s_next.ready = 1'b0;
        if (!s_reg.busy)
        begin
            s_next.std = 1'b1;
            s_next.ir = 1'b0;
            if (byte_valid_i && s_reg.ready)
            begin
                s_next.busy = 1'b1;
                s_next.shift = {1'b1, byte_i, 1'b0};
                s_next.bitn = 4'h0;
                s_next.tick = 5'h00;
            end
        end
        else
        begin
            s_next.std = s_reg.shift[0];
            s_next.ir = !s_reg.shift[0] && (s_reg.tick < IR_PULSE);
            s_next.tick = s_reg.tick + 5'h01;
            if (s_reg.tick == BIT_LAST)
            begin
                s_next.tick = 5'h00;
                s_next.shift = {1'b1, s_reg.shift[9:1]};
                s_next.bitn = s_reg.bitn + 4'h1;
                if (s_reg.bitn == FRAME_LAST)
                    s_next.busy = 1'b0;
            end
        end
        s_next.ready = !s_next.busy && cts_ok_i;
        // a high ir pulse marks a zero bit for one bit time
        if (!ir_mode_i)
            s_next.rx_bit = rx_pin_i;
        else if (rx_pin_i)
        begin
            s_next.rcnt = BIT_LAST;
            s_next.rx_bit = 1'b0;
        end
        else if (s_reg.rcnt != 5'h00)
            s_next.rcnt = s_reg.rcnt - 5'h01;
        else
            s_next.rx_bit = 1'b1;
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
            s_reg.shift <= 10'h3FF;
            s_reg.std <= 1'b1;
            s_reg.rx_bit <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign byte_ready_o = s_reg.ready;
    assign tx_std_o = s_reg.std;
    assign tx_ir_o = s_reg.ir;
    assign rx_bit_o = s_reg.rx_bit;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_accept;
        byte_valid_i && byte_ready_o;
    endsequence

    property p_cts_gate;
        byte_ready_o |-> $past(cts_ok_i);
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("start while cts held off");

    property p_start_bit;
        s_accept |=> ##1 !tx_std_o;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");

    property p_idle_levels;
        !s_reg.busy |=> tx_std_o && !tx_ir_o;
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("bad idle level");
endmodule

// ==== hw/ready_status.sv ====
// per channel and combined transmitter and receiver ready outputs
`timescale 1ns/1ns
module ready_status
    import quad_uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input chan_cfg_t [NUM_CH-1:0] cfg_i,
    input fifo_fill_t [NUM_CH-1:0] fill_i,
    output logic [NUM_CH-1:0] tx_ready_n_o,
    output logic [NUM_CH-1:0] rx_ready_n_o,
    output logic tx_all_n_o,
    output logic rx_all_n_o
);
    typedef struct packed {
        logic [NUM_CH-1:0] tx_n;
        logic [NUM_CH-1:0] rx_n;
        logic tx_all;
        logic rx_all;
    } rdy_state_t;

    rdy_state_t s_reg;
    rdy_state_t s_next;

    // mode 0 tracks empty or not, mode 1 tracks space and trigger level
    always_comb
    begin
        s_next = s_reg;
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (dma_mode1(cfg_i[c].fcr))
            begin
                s_next.tx_n[c] = (fill_i[c].tx_level >= FIFO_DEPTH);
                if (fill_i[c].rx_level >= rx_trigger(cfg_i[c].fcr))
                    s_next.rx_n[c] = 1'b0;
                else if (fill_i[c].rx_level == 7'h00)
                    s_next.rx_n[c] = 1'b1;
            end
            else
            begin
                s_next.tx_n[c] = (fill_i[c].tx_level != 7'h00);
                s_next.rx_n[c] = (fill_i[c].rx_level == 7'h00);
            end
        end
        s_next.tx_all = &s_next.tx_n;
        s_next.rx_all = &s_next.rx_n;
    end

    // state register, all ready outputs released in reset
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            s_reg <= '1;
        else
            s_reg <= s_next;
    end

    assign tx_ready_n_o = s_reg.tx_n;
    assign rx_ready_n_o = s_reg.rx_n;
    assign tx_all_n_o = s_reg.tx_all;
    assign rx_all_n_o = s_reg.rx_all;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_tx_all;
        tx_all_n_o == &tx_ready_n_o;
    endproperty
    a_tx_all: assert property (p_tx_all) else $error("combined tx ready wrong");

    property p_rx_all;
        rx_all_n_o == &rx_ready_n_o;
    endproperty
    a_rx_all: assert property (p_rx_all) else $error("combined rx ready wrong");

    property p_rx_mode0;
        !dma_mode1(cfg_i[0].fcr) |=> rx_ready_n_o[0] == ($past(fill_i[0].rx_level) == 7'h00);
    endproperty
    a_rx_mode0: assert property (p_rx_mode0) else $error("rx ready mode 0 wrong");

    property p_tx_mode0;
        !dma_mode1(cfg_i[0].fcr) |=> tx_ready_n_o[0] == ($past(fill_i[0].tx_level) != 7'h00);
    endproperty
    a_tx_mode0: assert property (p_tx_mode0) else $error("tx ready mode 0 wrong");
endmodule

// ==== hw/quad_uart_pins.sv ====
// pin level logic of a four channel uart: ready pins, status byte, serial pins
//
// Contract
// - per channel active low transmitter ready output
// - per channel active low receiver ready output
// - combined tx ready is and of four
// - combined rx ready is and of four
// - status select read drives summary byte
// - low nibble holds inverted tx ready, A lowest
// - high nibble holds rx ready, A lowest
// - summary read ignores the address lines
// - infrared bit clear gives standard serial pins
// - standard transmit idles high, also in reset
// - infrared bit set gives infrared encode and decode
// - infrared transmit idles low
// - dedicated infrared output always encoded, idles low
// - rts asserted first, then auto rts follows fill
// - auto cts gates transmission on cts
// - rts is software output without auto
// - cts is software readable input without auto
// - dtr is a software driven output
`timescale 1ns/1ns
module quad_uart_pins
    import quad_uart_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [quad_uart_pkg::NUM_CH-1:0] cs_n_i,
    input wire logic [2:0] addr_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    input wire logic status_byte_select_n_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input quad_uart_pkg::fifo_fill_t [quad_uart_pkg::NUM_CH-1:0] fill_i,
    input wire logic [quad_uart_pkg::NUM_CH-1:0][7:0] tx_byte_i,
    input wire logic [quad_uart_pkg::NUM_CH-1:0] tx_byte_valid_i,
    output logic [quad_uart_pkg::NUM_CH-1:0] tx_byte_ready_o,
    input wire logic [quad_uart_pkg::NUM_CH-1:0] rx_i,
    output logic [quad_uart_pkg::NUM_CH-1:0] rx_bit_o,
    output logic [quad_uart_pkg::NUM_CH-1:0] tx_o,
    output logic [quad_uart_pkg::NUM_CH-1:0] infrared_tx_out_o,
    output logic [quad_uart_pkg::NUM_CH-1:0] rts_n_o,
    input wire logic [quad_uart_pkg::NUM_CH-1:0] cts_n_i,
    output logic [quad_uart_pkg::NUM_CH-1:0] dtr_n_o,
    output logic [quad_uart_pkg::NUM_CH-1:0] tx_ready_n_o,
    output logic [quad_uart_pkg::NUM_CH-1:0] rx_ready_n_o,
    output logic tx_ready_all_n_o,
    output logic rx_ready_all_n_o
);
    import quad_uart_pkg::*;

    typedef struct packed {
        pins_t meta;
        pins_t sync;
        logic wr_prev;
        chan_cfg_t [NUM_CH-1:0] cfg;
        logic [7:0] rdata;
        logic rd_oe;
        logic [NUM_CH-1:0] tx;
        logic [NUM_CH-1:0] infrared_tx_out;
        logic [NUM_CH-1:0] rts_n;
        logic [NUM_CH-1:0] dtr_n;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;
    pins_t pins_now;
    logic [NUM_CH-1:0] lane_std;
    logic [NUM_CH-1:0] lane_ir;
    logic [NUM_CH-1:0] cts_ok;
    logic [NUM_CH-1:0] ir_mode;
    chan_cfg_t [NUM_CH-1:0] cfg;

    // gather every pin that needs a two stage synchroniser
    always_comb
    begin
        pins_now.cs_n = cs_n_i;
        pins_now.addr = addr_i;
        pins_now.rd_n = rd_n_i;
        pins_now.wr_n = wr_n_i;
        pins_now.sel_n = status_byte_select_n_i;
        pins_now.data = data_i;
        pins_now.cts_n = cts_n_i;
        pins_now.rx = rx_i;
    end

    // per channel lane controls from the register copy
    always_comb
    begin
        cfg = s_reg.cfg;
        for (int c = 0; c < NUM_CH; c++)
        begin
            ir_mode[c] = s_reg.cfg[c].modem_control_reg[MCR_IR_BIT];
            cts_ok[c] = !s_reg.cfg[c].enhanced_feature_reg[EFR_AUTO_CTS_BIT] || !s_reg.sync.cts_n[c];
        end
    end

    // one serialiser per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_lane
            uart_lane u_lane (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .ir_mode_i(ir_mode[g]),
                .cts_ok_i(cts_ok[g]),
                .byte_i(tx_byte_i[g]),
                .byte_valid_i(tx_byte_valid_i[g]),
                .byte_ready_o(tx_byte_ready_o[g]),
                .tx_std_o(lane_std[g]),
                .tx_ir_o(lane_ir[g]),
                .rx_pin_i(s_reg.sync.rx[g]),
                .rx_bit_o(rx_bit_o[g])
            );
        end
    endgenerate

    // ready pins for all four channels
    ready_status u_ready (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(cfg),
        .fill_i(fill_i),
        .tx_ready_n_o(tx_ready_n_o),
        .rx_ready_n_o(rx_ready_n_o),
        .tx_all_n_o(tx_ready_all_n_o),
        .rx_all_n_o(rx_ready_all_n_o)
    );

    // bus access, flow control and serial pin selection
    always_comb
    begin
        s_next = s_reg;
        s_next.meta = pins_now;
        s_next.sync = s_reg.meta;
        s_next.wr_prev = s_reg.sync.wr_n;
        // register write on the rising edge of the write strobe
        if (s_reg.sync.wr_n && !s_reg.wr_prev)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (!s_reg.sync.cs_n[c])
                begin
                    case (s_reg.sync.addr)
                        REG_IER: s_next.cfg[c].interrupt_enable_reg = s_reg.sync.data;
                        REG_FCR: s_next.cfg[c].fcr = s_reg.sync.data;
                        REG_MCR: s_next.cfg[c].modem_control_reg = s_reg.sync.data;
                        REG_EFR: s_next.cfg[c].enhanced_feature_reg = s_reg.sync.data;
                        default: ;
                    endcase
                end
            end
        end
        // read data; the summary select wins over any chip select
        s_next.rd_oe = 1'b0;
        s_next.rdata = 8'h00;
        if (!s_reg.sync.rd_n)
        begin
            if (!s_reg.sync.sel_n)
            begin
                s_next.rd_oe = 1'b1;
                s_next.rdata = {rx_ready_n_o, ~tx_ready_n_o};
            end
            else
            begin
                for (int c = NUM_CH - 1; c >= 0; c--)
                begin
                    if (!s_reg.sync.cs_n[c])
                    begin
                        s_next.rd_oe = 1'b1;
                        case (s_reg.sync.addr)
                            REG_IER: s_next.rdata = s_reg.cfg[c].interrupt_enable_reg;
                            REG_MCR: s_next.rdata = s_reg.cfg[c].modem_control_reg;
                            REG_EFR: s_next.rdata = s_reg.cfg[c].enhanced_feature_reg;
                            REG_MSR:
                            begin
                                s_next.rdata = 8'h00;
                                s_next.rdata[MSR_CTS_BIT] = !s_reg.sync.cts_n[c];
                            end
                            default: s_next.rdata = 8'h00;
                        endcase
                    end
                end
            end
        end
        // modem outputs and transmit pin selection
        for (int c = 0; c < NUM_CH; c++)
        begin
            s_next.dtr_n[c] = !s_reg.cfg[c].modem_control_reg[MCR_DTR_BIT];
            if (s_reg.cfg[c].enhanced_feature_reg[EFR_AUTO_RTS_BIT])
            begin
                // auto rts only once software has asserted rts
                s_next.rts_n[c] = !s_reg.cfg[c].modem_control_reg[MCR_RTS_BIT]
                    || (fill_i[c].rx_level >= rx_trigger(s_reg.cfg[c].fcr));
            end
            else
                s_next.rts_n[c] = !s_reg.cfg[c].modem_control_reg[MCR_RTS_BIT];
            s_next.tx[c] = ir_mode[c] ? lane_ir[c] : lane_std[c];
            s_next.infrared_tx_out[c] = lane_ir[c];
        end
    end

    // state register; serial output high and pins released in reset
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_reg <= '0;
            s_reg.meta <= '1;
            s_reg.sync <= '1;
            s_reg.wr_prev <= 1'b1;
            s_reg.tx <= '1;
            s_reg.rts_n <= '1;
            s_reg.dtr_n <= '1;
        end
        else
            s_reg <= s_next;
    end

    assign data_o = s_reg.rdata;
    assign data_oe_o = s_reg.rd_oe;
    assign tx_o = s_reg.tx;
    assign infrared_tx_out_o = s_reg.infrared_tx_out;
    assign rts_n_o = s_reg.rts_n;
    assign dtr_n_o = s_reg.dtr_n;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_summary_read;
        !s_reg.sync.rd_n && !s_reg.sync.sel_n;
    endsequence

    property p_summary;
        s_summary_read |=> data_oe_o && data_o == {$past(rx_ready_n_o), ~$past(tx_ready_n_o)};
    endproperty
    a_summary: assert property (p_summary) else $error("summary byte wrong");

    property p_no_addr;
        s_summary_read ##1 $changed(s_reg.sync.addr) && !s_reg.sync.rd_n && !s_reg.sync.sel_n
            |=> data_o == {$past(rx_ready_n_o), ~$past(tx_ready_n_o)};
    endproperty
    a_no_addr: assert property (p_no_addr) else $error("summary follows address");

    property p_pin_path;
        !s_reg.sync.rd_n && !s_reg.sync.sel_n |=> data_oe_o;
    endproperty
    a_pin_path: assert property (p_pin_path) else $error("summary not driven");

    property p_tx_select;
        1'b1 |=> tx_o[0] == ($past(ir_mode[0]) ? $past(lane_ir[0]) : $past(lane_std[0]));
    endproperty
    a_tx_select: assert property (p_tx_select) else $error("tx mode select wrong");

    property p_ir_short;
        infrared_tx_out_o[0] |-> ##[1:3] !infrared_tx_out_o[0];
    endproperty
    a_ir_short: assert property (p_ir_short) else $error("ir pulse too long");

    property p_rts_soft;
        !s_reg.cfg[1].enhanced_feature_reg[EFR_AUTO_RTS_BIT] |=> rts_n_o[1] == !$past(s_reg.cfg[1].modem_control_reg[MCR_RTS_BIT]);
    endproperty
    a_rts_soft: assert property (p_rts_soft) else $error("rts not software level");

    property p_rts_auto;
        s_reg.cfg[1].enhanced_feature_reg[EFR_AUTO_RTS_BIT] && !s_reg.cfg[1].modem_control_reg[MCR_RTS_BIT] |=> rts_n_o[1];
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("auto rts without rts");

    property p_dtr;
        1'b1 |=> dtr_n_o[2] == !$past(s_reg.cfg[2].modem_control_reg[MCR_DTR_BIT]);
    endproperty
    a_dtr: assert property (p_dtr) else $error("dtr not software level");
endmodule

// ==== tb/serial_far_end.sv ====
// far end serial model: idle receive lines, clear to send, channel a frame decoder
`timescale 1ns/1ns
module serial_far_end
(
    input wire logic clk_i,
    input wire logic watch_i,
    input wire logic tx_i,
    input wire logic cts_hold_i,
    output logic [3:0] rx_o,
    output logic [3:0] cts_n_o,
    output logic [7:0] frame_o,
    output logic [7:0] frame_cnt_o
);
    logic busy = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic [7:0] shreg = 8'h00;
    // receive lines idle high, no traffic sent
    assign rx_o = 4'hF;
    assign cts_n_o = {4{cts_hold_i}};
    initial frame_o = 8'h00;
    initial frame_cnt_o = 8'h00;
    // start bit found, then data sampled mid bit, lsb first
    always @(posedge clk_i)
    begin
        if (!busy)
        begin
            busy <= watch_i && (tx_i === 1'b0);
            cnt <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 8'h01;
            if (cnt[3:0] == 4'h7 && cnt[7:4] >= 4'h1 && cnt[7:4] <= 4'h8)
                shreg <= {tx_i, shreg[7:1]};
            if (cnt == 8'h97)
            begin
                busy <= 1'b0;
                frame_o <= shreg;
                frame_cnt_o <= frame_cnt_o + 8'h01;
            end
        end
    end
endmodule

// ==== tb/quad_uart_pins_tb.sv ====
// self checking bench for the quad uart pin logic
`timescale 1ns/1ns
module quad_uart_pins_tb;
    import quad_uart_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cs_n = 4'hF;
    logic [2:0] addr = 3'h0;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic sel_n = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    fifo_fill_t [NUM_CH-1:0] fill = '0;
    logic [NUM_CH-1:0][7:0] tx_byte = '0;
    logic [3:0] tx_valid = 4'h0;
    logic watch = 1'b0;
    logic cts_hold = 1'b1;
    logic [3:0] rx, cts_n, tx, infrared_tx_out, rts_n, dtr_n, txr_n, rxr_n, rdy, rxb;
    logic [7:0] data_o, frame, frame_cnt;
    logic oe, tx_all_n, rx_all_n;
    int fail_count = 0;
    int n_checks = 0;
    int ir_hi, tx_hi;
    logic [3:0] txm [3] = '{4'h1, 4'hF, 4'h0};
    logic [3:0] rxm [3] = '{4'h2, 4'h0, 4'hF};

    always #4 clk = ~clk;

    quad_uart_pins quad_uart_pins_inst (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
        .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdata),
        .status_byte_select_n_i(sel_n), .data_o(data_o), .data_oe_o(oe), .fill_i(fill),
        .tx_byte_i(tx_byte), .tx_byte_valid_i(tx_valid), .tx_byte_ready_o(rdy), .rx_i(rx),
        .rx_bit_o(rxb), .tx_o(tx), .infrared_tx_out_o(infrared_tx_out), .rts_n_o(rts_n), .cts_n_i(cts_n),
        .dtr_n_o(dtr_n), .tx_ready_n_o(txr_n), .rx_ready_n_o(rxr_n),
        .tx_ready_all_n_o(tx_all_n), .rx_ready_all_n_o(rx_all_n));

    serial_far_end serial_far_end_inst (.clk_i(clk), .watch_i(watch), .tx_i(tx[0]),
        .cts_hold_i(cts_hold), .rx_o(rx), .cts_n_o(cts_n), .frame_o(frame),
        .frame_cnt_o(frame_cnt));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // pin level write, strobe and data held past the synchroniser
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 4'hE;
        addr <= a;
        wdata <= d;
        wr_n <= 1'b0;
        cyc(5);
        wr_n <= 1'b1;
        cyc(5);
        cs_n <= 4'hF;
        cyc(1);
    endtask

    // pin level read, channel a or status select
    task automatic rd(input logic sel, input logic [2:0] a);
        @(posedge clk);
        cs_n <= sel ? 4'hE : 4'hF;
        sel_n <= sel;
        addr <= a;
        rd_n <= 1'b0;
        cyc(5);
        rdata = data_o;
        check({7'h00, oe}, 8'h01, "data_oe");
        rd_n <= 1'b1;
        sel_n <= 1'b1;
        cs_n <= 4'hF;
        cyc(5);
    endtask

    // hand one byte to lane a and count high cycles on both transmit pins
    task automatic send(input logic [7:0] b);
        int k;
        k = 0;
        ir_hi = 0;
        tx_hi = 0;
        @(posedge clk);
        tx_byte[0] <= b;
        tx_valid <= 4'h1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (rdy[0] !== 1'b1 && k < 400);
        tx_valid <= 4'h0;
        check({7'h00, rdy[0]}, 8'h01, "accept");
        repeat (175)
        begin
            @(posedge clk);
            ir_hi += int'(infrared_tx_out[0]);
            tx_hi += int'(tx[0]);
        end
    endtask

    initial
    begin
        cyc(4);
        check({4'h0, tx}, 8'h0F, "tx in reset");
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        check({infrared_tx_out, rts_n}, 8'h0F, "infrared_tx_out rts idle");
        check({dtr_n, rxb}, 8'hFF, "dtr rx idle");
        // ready pins and summary byte over fill patterns, address varied
        for (int p = 0; p < 3; p++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                fill[c].tx_level <= txm[p][c] ? 7'h05 : 7'h00;
                fill[c].rx_level <= rxm[p][c] ? 7'h03 : 7'h00;
            end
            cyc(3);
            check({txr_n, rxr_n}, {txm[p], ~rxm[p]}, "ready_n");
            check({6'h00, tx_all_n, rx_all_n}, {6'h00, &txm[p], &(~rxm[p])}, "all_n");
            rd(1'b0, 3'(p * 3));
            check(rdata, {~rxm[p], ~txm[p]}, "summary");
        end
        // fifo plus dma mode: full threshold and trigger hysteresis
        fill <= '0;
        wr(REG_FCR, 8'h09);
        fill[0].tx_level <= 7'h3F;
        fill[0].rx_level <= 7'h07;
        cyc(3);
        check({txr_n[0], rxr_n[0]}, 8'h01, "mode1 low");
        fill[0].tx_level <= 7'h40;
        fill[0].rx_level <= 7'h08;
        cyc(3);
        check({txr_n[0], rxr_n[0]}, 8'h02, "mode1 high");
        fill[0].rx_level <= 7'h03;
        cyc(3);
        check({7'h00, rxr_n[0]}, 8'h00, "mode1 hold");
        // software modem pins and clear to send status
        wr(REG_MCR, 8'h03);
        cyc(2);
        check({dtr_n, rts_n}, 8'hEE, "dtr rts");
        rd(1'b1, REG_MCR);
        check(rdata, 8'h03, "mcr readback");
        rd(1'b1, REG_MSR);
        check(rdata & 8'h10, 8'h00, "msr cts off");
        cts_hold <= 1'b0;
        rd(1'b1, REG_MSR);
        check(rdata & 8'h10, 8'h10, "msr cts on");
        // automatic request to send follows receive fill
        wr(REG_EFR, 8'h40);
        fill[0].rx_level <= 7'h08;
        cyc(3);
        check({4'h0, rts_n}, 8'h0F, "auto rts full");
        fill[0].rx_level <= 7'h02;
        cyc(3);
        check({4'h0, rts_n}, 8'h0E, "auto rts room");
        // standard frame decoded by the far end, infrared pin pulses anyway
        wr(REG_EFR, 8'h00);
        watch <= 1'b1;
        send(8'hF0);
        check(frame, 8'hF0, "std frame");
        check(frame_cnt, 8'h01, "frame count");
        check(8'(ir_hi), 8'h0F, "infrared_tx_out pulses std");
        // infrared mode on the main transmit pin
        watch <= 1'b0;
        wr(REG_MCR, 8'h43);
        cyc(2);
        check({7'h00, tx[0]}, 8'h00, "ir idle");
        send(8'hF0);
        check(8'(tx_hi), 8'h0F, "tx ir pulses");
        check(8'(ir_hi), 8'h0F, "infrared_tx_out pulses ir");
        // automatic clear to send holds the lane off
        wr(REG_MCR, 8'h03);
        wr(REG_EFR, 8'h80);
        cts_hold <= 1'b1;
        cyc(6);
        check({7'h00, rdy[0]}, 8'h00, "cts held");
        cts_hold <= 1'b0;
        watch <= 1'b1;
        send(8'h5A);
        check(frame, 8'h5A, "cts frame");
        print_verdict();
    end

    // cut a hang short
    initial
    begin
        cyc(20000);
        fail_count++;
        print_verdict();
    end
endmodule
